//--- dv/drive_fieldbus_control_status_sva.sv
module fieldbus_ctl_checker (
    // clock and reset
    input wire logic        sys_clk_in,
    input wire logic        rst_n_in,
    // dictionary access
    input wire logic        od_wr_in,
    input wire logic [15:0] od_index_in,
    input wire logic [31:0] od_wdata_in,
    input wire logic        od_err_out,
    // configuration and drive state
    input wire logic [3:0]  cmd_source_in,
    input wire logic [3:0]  term_source_in,
    input wire logic        running_in,
    input wire logic        tripped_in,
    input wire logic        standby_in,
    input wire logic        hw_enable_in,
    input wire logic        mains_loss_in,
    input wire logic [7:0]  fault_code_in,
    // motor command and status
    input wire logic        run_out,
    input wire logic        fast_stop_out,
    input wire logic        coast_out,
    input wire logic        trip_reset_out,
    input wire logic        term_ctl_out,
    input wire logic        ramp_valid_out,
    input wire logic [15:0] state_word_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    logic       serial_src;
    logic       ctl_ok;
    logic       cmd_wr;
    logic [3:0] status_exp;
    logic [7:0] fault_exp;

    assign serial_src = cmd_source_in == drive_pkg::SRC_SERIAL_A ||
                        cmd_source_in == drive_pkg::SRC_SERIAL_B;
    assign ctl_ok = term_source_in <= drive_pkg::TERM_MAX &&
                    (serial_src || cmd_source_in == drive_pkg::SRC_CAN_A ||
                     cmd_source_in == drive_pkg::SRC_CAN_B);
    assign cmd_wr = od_wr_in && od_index_in == drive_pkg::IDX_CMD_WORD;
    // ready needs healthy, enabled and mains present together
    assign status_exp = {!tripped_in && hw_enable_in && !mains_loss_in,
                         standby_in, tripped_in, running_in};
    assign fault_exp = tripped_in ? fault_code_in : 8'h00;

    property p_run;
        cmd_wr && od_wdata_in[3:0] == 4'h1 ##1 ctl_ok |=> run_out;
    endproperty
    a_run: assert property (p_run) else $error("run not raised");
    property p_fast;
        cmd_wr && od_wdata_in[3:0] == 4'h3 ##1 ctl_ok
            |=> fast_stop_out && !run_out;
    endproperty
    a_fast: assert property (p_fast) else $error("fast stop lost");
    property p_coast;
        cmd_wr && od_wdata_in[3:0] == 4'h9 ##1 ctl_ok
            |=> coast_out && !run_out && !fast_stop_out;
    endproperty
    a_coast: assert property (p_coast) else $error("coast lost");
    property p_term;
        term_source_in > drive_pkg::TERM_MAX |=> term_ctl_out && !run_out;
    endproperty
    a_term: assert property (p_term) else $error("terminal mode");
    property p_trip_rst;
        cmd_wr && od_wdata_in[2] ##1 tripped_in && serial_src
            |=> trip_reset_out;
    endproperty
    a_trip_rst: assert property (p_trip_rst) else $error("trip");
    property p_ramp_valid;
        1 |=> ramp_valid_out ==
              ($past(cmd_source_in) == drive_pkg::SRC_SERIAL_B);
    endproperty
    a_ramp_valid: assert property (p_ramp_valid) else $error("ramp");
    property p_status;
        1 |=> {state_word_out[6:5], state_word_out[1:0]} == $past(status_exp);
    endproperty
    a_status: assert property (p_status) else $error("status");
    property p_fault;
        1 |=> state_word_out[15:8] == $past(fault_exp);
    endproperty
    a_fault: assert property (p_fault) else $error("fault byte");
    property p_ro_ident;
        od_wr_in && od_index_in == drive_pkg::IDX_IDENTITY |=> od_err_out;
    endproperty
    a_ro_ident: assert property (p_ro_ident) else $error("ident");

    c_coast: cover property (coast_out);
    c_trip_reset: cover property (trip_reset_out);
    c_refused: cover property (od_err_out);
endmodule

bind drive_fieldbus_control_status fieldbus_ctl_checker chk_u (
    .sys_clk_in, .rst_n_in, .od_wr_in, .od_index_in, .od_wdata_in,
    .od_err_out, .cmd_source_in, .term_source_in, .running_in, .tripped_in,
    .standby_in, .hw_enable_in, .mains_loss_in, .fault_code_in, .run_out,
    .fast_stop_out, .coast_out, .trip_reset_out, .term_ctl_out,
    .ramp_valid_out, .state_word_out);

//--- dv/drive_fieldbus_control_status_tb.sv
module drive_fieldbus_control_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] VENDOR = 32'h0000_5A5A; // arbitrary
    localparam logic [6:0]  NODE   = 7'h05;
    logic        sys_clk_in, rst_n_in, od_rd, od_wr, od_ack, od_err;
    logic [15:0] od_index, max_speed, speed_cmd, ramp_cmd, state_word;
    logic [7:0]  od_sub, fault_code;
    logic [31:0] od_wdata, od_rdata;
    logic [3:0]  cmd_source, term_source;
    logic        running, tripped, standby, hw_enable, mains_loss;
    logic        run, fast, coast, trip_rst, term_ctl, ramp_valid;
    int          errors, comparisons;

    drive_fieldbus_control_status #(.VENDOR_CODE(VENDOR)) dut_u (
        .sys_clk_in, .rst_n_in, .od_rd_in(od_rd), .od_wr_in(od_wr),
        .od_index_in(od_index), .od_sub_in(od_sub), .od_wdata_in(od_wdata),
        .od_rdata_out(od_rdata), .od_ack_out(od_ack), .od_err_out(od_err),
        .node_id_in(NODE), .cmd_source_in(cmd_source),
        .term_source_in(term_source), .max_speed_in(max_speed),
        .running_in(running), .tripped_in(tripped), .standby_in(standby),
        .hw_enable_in(hw_enable), .mains_loss_in(mains_loss),
        .fault_code_in(fault_code), .error_summary_in(8'h3C),
        .maker_status_in(16'h0000), .run_out(run), .fast_stop_out(fast),
        .coast_out(coast), .trip_reset_out(trip_rst),
        .term_ctl_out(term_ctl), .speed_cmd_out(speed_cmd),
        .ramp_cmd_out(ramp_cmd), .ramp_valid_out(ramp_valid),
        .state_word_out(state_word));
    fieldbus_master master_u (
        .sys_clk_in, .od_ack_in(od_ack), .od_err_in(od_err),
        .od_rdata_in(od_rdata), .od_rd_out(od_rd), .od_wr_out(od_wr),
        .od_index_out(od_index), .od_sub_out(od_sub),
        .od_wdata_out(od_wdata));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [15:0] idx,
                       input logic [7:0] sub, input logic [31:0] wd,
                       input logic [31:0] exp, input logic err_exp);
        logic [31:0] d;
        logic [1:0]  ae;
        master_u.access(wr, idx, sub, wd, d, ae);
        chk({30'h0, ae}, {30'h0, 1'b1, err_exp});
        if (!wr) begin
            chk(d, exp);
        end
    endtask
    task automatic t_defaults();
        logic [31:0] rx [4] = '{32'h2000_0010, 32'h2001_0010,
                                32'h2003_0010, 32'h0006_0010};
        logic [31:0] tx [4] = '{32'h200A_0010, 32'h200B_0010,
                                32'h200D_0010, 32'h2010_0010};
        acc(1'b0, 16'h1005, 8'h0, '0, 32'h80, 1'b0);
        acc(1'b0, 16'h1014, 8'h0, '0, 32'h80 + NODE, 1'b0);
        acc(1'b0, 16'h1015, 8'h0, '0, '0, 1'b0);
        acc(1'b0, 16'h1017, 8'h0, '0, '0, 1'b0);
        acc(1'b0, 16'h1018, 8'h0, '0, 32'h4, 1'b0);
        acc(1'b0, 16'h1200, 8'h1, '0, 32'h600 + NODE, 1'b0);
        acc(1'b0, 16'h1600, 8'h0, '0, 32'h4, 1'b0);
        for (int i = 0; i < 4; i++) begin
            acc(1'b0, 16'h1600, 8'(i + 1), '0, rx[i], 1'b0);
            acc(1'b0, 16'h1A00, 8'(i + 1), '0, tx[i], 1'b0);
        end
    endtask
    task automatic t_regs();
        acc(1'b1, 16'h1017, 8'h0, 32'h1234, '0, 1'b0);
        acc(1'b0, 16'h1017, 8'h0, '0, 32'h1234, 1'b0);
        acc(1'b1, 16'h1015, 8'h0, 32'hBEEF, '0, 1'b0);
        acc(1'b0, 16'h1015, 8'h0, '0, 32'hBEEF, 1'b0);
        acc(1'b1, 16'h1018, 8'h1, '1, '0, 1'b1);
        acc(1'b0, 16'h1018, 8'h1, '0, VENDOR, 1'b0);
        acc(1'b1, 16'h1200, 8'h2, '1, '0, 1'b1);
        acc(1'b0, 16'h1200, 8'h2, '0, 32'h580 + NODE, 1'b0);
        acc(1'b0, 16'h1001, 8'h0, '0, 32'h3C, 1'b0);
        acc(1'b0, 16'h3000, 8'h0, '0, '0, 1'b1);
    endtask
    task automatic t_commands();
        logic [3:0]  srcs [4] = '{4'h3, 4'h4, 4'h7, 4'h8};
        logic [15:0] words [5] = '{16'h0001, 16'h0003, 16'h0009,
                                   16'h000B, 16'h0002};
        logic [31:0] modes [5] = '{1, 2, 4, 4, 2};
        foreach (srcs[i]) foreach (words[j]) begin
            @(negedge sys_clk_in);
            cmd_source = srcs[i];
            term_source = {3'h0, j[0]};
            acc(1'b1, 16'h2000, 8'h0, {16'h0, words[j]}, '0, 1'b0);
            @(negedge sys_clk_in);
            chk({29'h0, coast, fast, run}, modes[j]);
        end
        term_source = 4'h2;
        acc(1'b1, 16'h2000, 8'h0, 32'h1, '0, 1'b0);
        @(negedge sys_clk_in);
        chk({30'h0, term_ctl, run}, 32'h2);
        term_source = 4'h0;
        cmd_source = 4'h5;
        @(negedge sys_clk_in);
        chk({31'h0, run}, '0);
    endtask
    task automatic t_trip();
        @(negedge sys_clk_in);
        {cmd_source, term_source, tripped, fault_code} = {8'h32, 1'b1, 8'h2A};
        acc(1'b1, 16'h2000, 8'h0, 32'h4, '0, 1'b0);
        @(negedge sys_clk_in);
        chk({31'h0, trip_rst}, 32'h1);
        chk({16'h0, state_word & 16'hFF42}, 32'h2A02);
        cmd_source = 4'h7;
        @(negedge sys_clk_in);
        chk({31'h0, trip_rst}, '0);
        {cmd_source, tripped} = {4'h4, 1'b0};
        @(negedge sys_clk_in);
        chk({15'h0, trip_rst, state_word[15:8], 8'h0}, '0);
        acc(1'b1, 16'h2000, 8'h0, '0, '0, 1'b0);
    endtask
    task automatic t_speed();
        logic [15:0] sent [3] = '{16'd200, 16'd800, 16'hFCE0};
        logic [15:0] held [3] = '{16'd200, 16'd500, 16'hFE0C};
        foreach (sent[i]) begin
            acc(1'b1, 16'h2001, 8'h0, {16'h0, sent[i]}, '0, 1'b0);
            @(negedge sys_clk_in);
            chk({16'h0, speed_cmd}, {16'h0, held[i]});
        end
        acc(1'b1, 16'h2003, 8'h0, 32'd500, '0, 1'b0);
        @(negedge sys_clk_in);
        chk({15'h0, ramp_valid, ramp_cmd}, 32'h1_01F4);
        cmd_source = 4'h3;
        @(negedge sys_clk_in);
        chk({31'h0, ramp_valid}, '0);
    endtask
    task automatic t_status();
        for (int i = 0; i < 16; i++) begin
            @(negedge sys_clk_in);
            {running, standby, hw_enable, mains_loss} = i[3:0];
            @(negedge sys_clk_in);
            chk({16'h0, state_word & 16'hFF63}, {25'h0,
                hw_enable & ~mains_loss, standby, 4'h0, running});
        end
    endtask
    task automatic complete_run();
        if (errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        errors++;
        complete_run();
    end
    initial begin
        {rst_n_in, cmd_source, term_source} = {1'b0, 8'h70};
        {running, tripped, standby, hw_enable, mains_loss} = 5'h0;
        {max_speed, fault_code} = {16'h01F4, 8'h00};
        repeat (2) @(posedge sys_clk_in);
        @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        t_defaults();
        t_regs();
        t_commands();
        t_trip();
        t_speed();
        t_status();
        complete_run();
    end
endmodule

//--- dv/fieldbus_master.sv
module fieldbus_master (
    // clock
    input  wire logic        sys_clk_in,
    // answer from the drive
    input  wire logic        od_ack_in,
    input  wire logic        od_err_in,
    input  wire logic [31:0] od_rdata_in,
    // request to the drive
    output logic             od_rd_out,
    output logic             od_wr_out,
    output logic      [15:0] od_index_out,
    output logic      [7:0]  od_sub_out,
    output logic      [31:0] od_wdata_out
);
    initial begin
        {od_rd_out, od_wr_out, od_index_out} = '0;
        {od_sub_out, od_wdata_out} = '0;
    end

    // one-cycle request pulse, answer sampled one edge later
    task automatic access(input logic wr, input logic [15:0] idx,
                          input logic [7:0] sub, input logic [31:0] wd,
                          output logic [31:0] rd, output logic [1:0] ae);
        @(negedge sys_clk_in);
        od_rd_out = !wr;
        od_wr_out = wr;
        od_index_out = idx;
        od_sub_out = sub;
        od_wdata_out = wd;
        @(negedge sys_clk_in);
        {od_rd_out, od_wr_out} = 2'h0;
        @(posedge sys_clk_in);
        rd = od_rdata_in;
        ae = {od_ack_in, od_err_in};
        // released lines never keep the stale value
        od_index_out <= ~idx;
        od_sub_out <= ~sub;
        od_wdata_out <= ~wd;
    endtask
endmodule

//--- src/drive_fieldbus_control_status.sv
// Summary of operation
// - command bit 0 set runs the motor, clear gives a normal stop.
// - command bit 1 stops the motor on the second deceleration ramp.
// - command bit 2 clears a trip while the drive is tripped.
// - command bit 3 removes drive so the motor coasts to rest.
// - priority is coast over fast stop over run.
// - bits 0, 1 and 3 act only with terminal source 0 or 1.
// - bit 2 acts whenever command source is serial mode 3 or 4.
// - speed reference is counted in 0.1 Hz steps.
// - speed reference is limited to the configured maximum speed.
// - ramp value applies to accel and decel only with source 4.
// - ramp value is counted in 0.01 s steps.
// - state word upper byte carries the fault code while tripped.
// - state bits 0, 1, 5 show running, tripped and standby.
// - state bit 6 shows ready: untripped, enabled, mains present.
// - read-only identity record of four 32-bit entries.
// - writable 16-bit heartbeat period in 1 ms, default zero.
// - writable 16-bit emergency spacing in 100 us, default zero.
// - read-only SDO identifiers 0x600 and 0x580 plus node id.
// - default receive mapping: command, speed, ramp, dummy.
// - default transmit mapping: state, speed, current, temperature.
// - bus control acts only with command source 3, 4, 7 or 8.
module drive_fieldbus_control_status #(
    parameter logic [31:0] DEVICE_TYPE  = 32'h0000_0000,
    parameter logic [31:0] VENDOR_CODE  = 32'h0000_0ABC, // arbitrary
    parameter logic [31:0] PRODUCT_CODE = 32'h0000_0001, // arbitrary
    parameter logic [31:0] REVISION     = 32'h0000_0001, // arbitrary
    parameter logic [31:0] SERIAL_NO    = 32'h0000_0001  // arbitrary
) (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    // object dictionary access
    input  wire logic        od_rd_in,
    input  wire logic        od_wr_in,
    input  wire logic [15:0] od_index_in,
    input  wire logic [7:0]  od_sub_in,
    input  wire logic [31:0] od_wdata_in,
    output logic      [31:0] od_rdata_out,
    output logic             od_ack_out,
    output logic             od_err_out,
    // drive configuration
    input  wire logic [6:0]  node_id_in,
    input  wire logic [3:0]  cmd_source_in,
    input  wire logic [3:0]  term_source_in,
    input  wire logic [15:0] max_speed_in,
    // drive state
    input  wire logic        running_in,
    input  wire logic        tripped_in,
    input  wire logic        standby_in,
    input  wire logic        hw_enable_in,
    input  wire logic        mains_loss_in,
    input  wire logic [7:0]  fault_code_in,
    input  wire logic [7:0]  error_summary_in,
    input  wire logic [15:0] maker_status_in,
    // motor command and status
    output logic             run_out,
    output logic             fast_stop_out,
    output logic             coast_out,
    output logic             trip_reset_out,
    output logic             term_ctl_out,
    output logic      [15:0] speed_cmd_out,
    output logic      [15:0] ramp_cmd_out,
    output logic             ramp_valid_out,
    output logic      [15:0] state_word_out
);

    drive_pkg::state_s st_reg;
    drive_pkg::state_s st_next;

    // signed magnitude limit, applied in both directions
    function automatic logic [15:0] limit_speed(
        input logic [15:0] ref_val,
        input logic [15:0] lim
    );
        logic [15:0] mag;
        logic [15:0] neg_lim;
        mag = ref_val[15] ? 16'(-ref_val) : ref_val;
        neg_lim = 16'(-lim);
        limit_speed = ref_val;
        if (mag > lim) begin
            limit_speed = ref_val[15] ? neg_lim : lim;
        end
    endfunction

    function automatic logic is_serial(input logic [3:0] src);
        is_serial = (src == drive_pkg::SRC_SERIAL_A) ||
                    (src == drive_pkg::SRC_SERIAL_B);
    endfunction

    function automatic logic is_can(input logic [3:0] src);
        is_can = (src == drive_pkg::SRC_CAN_A) ||
                 (src == drive_pkg::SRC_CAN_B);
    endfunction

    logic        bus_src;
    logic        ctl_ok;
    logic        hit;
    logic        ro_obj;
    logic [31:0] rd_val;
    logic [31:0] node_ext;
    logic [1:0]  map_sel;

    assign node_ext = {25'h0, node_id_in};
    assign map_sel  = od_sub_in[1:0] - 2'h1;
    assign bus_src  = is_serial(cmd_source_in) ||
                      is_can(cmd_source_in);
    assign ctl_ok   = bus_src &&
                      (term_source_in <= drive_pkg::TERM_MAX);

    // dictionary decode: value, presence, and write protection
    always_comb begin
        rd_val = 32'h0;
        hit    = 1'b1;
        ro_obj = 1'b0;
        unique case (od_index_in)
            drive_pkg::IDX_DEV_TYPE: begin
                rd_val = DEVICE_TYPE;
                ro_obj = 1'b1;
            end
            drive_pkg::IDX_ERR_SUM: begin
                rd_val = {24'h0, error_summary_in};
                ro_obj = 1'b1;
            end
            drive_pkg::IDX_MAKER_ST: begin
                rd_val = {16'h0, maker_status_in};
                ro_obj = 1'b1;
            end
            drive_pkg::IDX_SYNC_ID:   rd_val = st_reg.sync_id;
            drive_pkg::IDX_GUARD:     rd_val = {16'h0, st_reg.guard};
            drive_pkg::IDX_LIFE:      rd_val = {24'h0, st_reg.life};
            drive_pkg::IDX_EMCY_ID: begin
                rd_val = st_reg.emcy_set ? st_reg.emcy_id
                       : drive_pkg::EMCY_ID_BASE + node_ext;
            end
            drive_pkg::IDX_EMCY_GAP:
                rd_val = {16'h0, st_reg.emcy_gap};
            drive_pkg::IDX_HEARTBEAT:
                rd_val = {16'h0, st_reg.heartbeat};
            drive_pkg::IDX_IDENTITY: begin
                ro_obj = 1'b1;
                unique case (od_sub_in)
                    8'h00: rd_val = {24'h0, drive_pkg::IDENT_COUNT};
                    8'h01: rd_val = VENDOR_CODE;
                    8'h02: rd_val = PRODUCT_CODE;
                    8'h03: rd_val = REVISION;
                    8'h04: rd_val = SERIAL_NO;
                    default: hit = 1'b0;
                endcase
            end
            drive_pkg::IDX_SDO: begin
                ro_obj = 1'b1;
                unique case (od_sub_in)
                    8'h00: rd_val = {24'h0, drive_pkg::SDO_COUNT};
                    8'h01: rd_val = drive_pkg::SDO_RX_BASE + node_ext;
                    8'h02: rd_val = drive_pkg::SDO_TX_BASE + node_ext;
                    default: hit = 1'b0;
                endcase
            end
            drive_pkg::IDX_RX_MAP: begin
                if (od_sub_in == 8'h00) begin
                    rd_val = {29'h0, st_reg.rx_cnt};
                end else if (od_sub_in <= 8'h04) begin
                    rd_val = st_reg.rx_map[map_sel];
                end else begin
                    hit = 1'b0;
                end
            end
            drive_pkg::IDX_TX_MAP: begin
                if (od_sub_in == 8'h00) begin
                    rd_val = {29'h0, st_reg.tx_cnt};
                end else if (od_sub_in <= 8'h04) begin
                    rd_val = st_reg.tx_map[map_sel];
                end else begin
                    hit = 1'b0;
                end
            end
            drive_pkg::IDX_CMD_WORD:  rd_val = {16'h0, st_reg.cmd};
            drive_pkg::IDX_SPEED_REF: rd_val = {16'h0, st_reg.speed};
            drive_pkg::IDX_RAMP_REF:  rd_val = {16'h0, st_reg.ramp};
            drive_pkg::IDX_STATE_WD: begin
                rd_val = {16'h0, st_reg.state_word};
                ro_obj = 1'b1;
            end
            default: hit = 1'b0;
        endcase
        if (!hit) begin
            ro_obj = 1'b1;
        end
    end

    always_comb begin
        st_next     = st_reg;
        st_next.ack = od_rd_in || od_wr_in;
        st_next.err = (od_rd_in && !hit) || (od_wr_in && ro_obj);
        if (od_rd_in) begin
            st_next.rdata = hit ? rd_val : 32'h0;
        end

        // writes to single objects land whatever the subindex
        if (od_wr_in && !ro_obj) begin
            unique case (od_index_in)
                drive_pkg::IDX_SYNC_ID: st_next.sync_id = od_wdata_in;
                drive_pkg::IDX_GUARD:   st_next.guard = od_wdata_in[15:0];
                drive_pkg::IDX_LIFE:    st_next.life = od_wdata_in[7:0];
                drive_pkg::IDX_EMCY_ID: begin
                    st_next.emcy_id  = od_wdata_in;
                    st_next.emcy_set = 1'b1;
                end
                drive_pkg::IDX_EMCY_GAP:
                    st_next.emcy_gap = od_wdata_in[15:0];
                drive_pkg::IDX_HEARTBEAT:
                    st_next.heartbeat = od_wdata_in[15:0];
                drive_pkg::IDX_RX_MAP: begin
                    if (od_sub_in == 8'h00) begin
                        st_next.rx_cnt = od_wdata_in[2:0];
                    end else begin
                        st_next.rx_map[map_sel] = od_wdata_in;
                    end
                end
                drive_pkg::IDX_TX_MAP: begin
                    if (od_sub_in == 8'h00) begin
                        st_next.tx_cnt = od_wdata_in[2:0];
                    end else begin
                        st_next.tx_map[map_sel] = od_wdata_in;
                    end
                end
                drive_pkg::IDX_CMD_WORD:  st_next.cmd = od_wdata_in[15:0];
                drive_pkg::IDX_SPEED_REF: st_next.speed = od_wdata_in[15:0];
                drive_pkg::IDX_RAMP_REF:  st_next.ramp = od_wdata_in[15:0];
                default: ;
            endcase
        end

        // motion command from the stored word
        st_next.term_ctl = !ctl_ok;
        if (!ctl_ok) begin
            st_next.motion = drive_pkg::MOTION_STOP;
        end else if (st_reg.cmd[drive_pkg::CW_COAST]) begin
            st_next.motion = drive_pkg::MOTION_COAST;
        end else if (st_reg.cmd[drive_pkg::CW_FAST]) begin
            st_next.motion = drive_pkg::MOTION_FAST;
        end else if (st_reg.cmd[drive_pkg::CW_RUN]) begin
            st_next.motion = drive_pkg::MOTION_RUN;
        end else begin
            st_next.motion = drive_pkg::MOTION_STOP;
        end

        // level held while tripped; drops at the first edge after tripped_in clears
        st_next.trip_rst = st_reg.cmd[drive_pkg::CW_RESET] &&
                           tripped_in &&
                           is_serial(cmd_source_in);

        // 0.1 Hz steps passed through, only the limit is applied
        st_next.speed_cmd = limit_speed(st_reg.speed,
                                        max_speed_in);
        // 0.01 s steps, one value for both ramps
        st_next.ramp_valid = (cmd_source_in ==
                              drive_pkg::SRC_SERIAL_B);
        if (st_next.ramp_valid) begin
            st_next.ramp_cmd = st_reg.ramp;
        end

        st_next.state_word = 16'h0;
        if (tripped_in) begin
            st_next.state_word[15:8] = fault_code_in;
        end
        st_next.state_word[drive_pkg::SW_RUN]  = running_in;
        st_next.state_word[drive_pkg::SW_TRIP] = tripped_in;
        st_next.state_word[drive_pkg::SW_STBY] = standby_in;
        st_next.state_word[drive_pkg::SW_READY] =
            !tripped_in && hw_enable_in && !mains_loss_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            st_reg            <= '0;
            st_reg.sync_id    <= drive_pkg::SYNC_ID_RST;
            st_reg.rx_map     <= drive_pkg::RX_MAP_RST;
            st_reg.tx_map     <= drive_pkg::TX_MAP_RST;
            st_reg.rx_cnt     <= drive_pkg::MAP_COUNT_RST;
            st_reg.tx_cnt     <= drive_pkg::MAP_COUNT_RST;
            st_reg.motion     <= drive_pkg::MOTION_STOP;
            st_reg.term_ctl   <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign od_rdata_out   = st_reg.rdata;
    assign od_ack_out     = st_reg.ack;
    assign od_err_out     = st_reg.err;
    assign run_out        = st_reg.motion == drive_pkg::MOTION_RUN;
    assign fast_stop_out  = st_reg.motion == drive_pkg::MOTION_FAST;
    assign coast_out      = st_reg.motion == drive_pkg::MOTION_COAST;
    assign trip_reset_out = st_reg.trip_rst;
    assign term_ctl_out   = st_reg.term_ctl;
    assign speed_cmd_out  = st_reg.speed_cmd;
    assign ramp_cmd_out   = st_reg.ramp_cmd;
    assign ramp_valid_out = st_reg.ramp_valid;
    assign state_word_out = st_reg.state_word;

endmodule

//--- src/drive_pkg.sv
package drive_pkg;
    // object dictionary indices
    localparam logic [15:0] IDX_DEV_TYPE  = 16'h1000;
    localparam logic [15:0] IDX_ERR_SUM   = 16'h1001;
    localparam logic [15:0] IDX_MAKER_ST  = 16'h1002;
    localparam logic [15:0] IDX_SYNC_ID   = 16'h1005;
    localparam logic [15:0] IDX_GUARD     = 16'h100C;
    localparam logic [15:0] IDX_LIFE      = 16'h100D;
    localparam logic [15:0] IDX_EMCY_ID   = 16'h1014;
    localparam logic [15:0] IDX_EMCY_GAP  = 16'h1015;
    localparam logic [15:0] IDX_HEARTBEAT = 16'h1017;
    localparam logic [15:0] IDX_IDENTITY  = 16'h1018;
    localparam logic [15:0] IDX_SDO       = 16'h1200;
    localparam logic [15:0] IDX_RX_MAP    = 16'h1600;
    localparam logic [15:0] IDX_TX_MAP    = 16'h1A00;
    localparam logic [15:0] IDX_CMD_WORD  = 16'h2000;
    localparam logic [15:0] IDX_SPEED_REF = 16'h2001;
    localparam logic [15:0] IDX_RAMP_REF  = 16'h2003;
    localparam logic [15:0] IDX_STATE_WD  = 16'h200A;
    // reset values
    localparam logic [31:0] SYNC_ID_RST   = 32'h0000_0080;
    localparam logic [31:0] EMCY_ID_BASE  = 32'h0000_0080;
    localparam logic [31:0] SDO_RX_BASE   = 32'h0000_0600;
    localparam logic [31:0] SDO_TX_BASE   = 32'h0000_0580;
    localparam logic [7:0]  IDENT_COUNT   = 8'h04;
    localparam logic [7:0]  SDO_COUNT     = 8'h02;
    localparam logic [2:0]  MAP_COUNT_RST = 3'h4;
    localparam logic [3:0][31:0] RX_MAP_RST = {
        32'h0006_0010, 32'h2003_0010, 32'h2001_0010, 32'h2000_0010};
    localparam logic [3:0][31:0] TX_MAP_RST = {
        32'h2010_0010, 32'h200D_0010, 32'h200B_0010, 32'h200A_0010};
    // command word bits
    localparam int CW_RUN   = 0;
    localparam int CW_FAST  = 1;
    localparam int CW_RESET = 2;
    localparam int CW_COAST = 3;
    // state word bits
    localparam int SW_RUN   = 0;
    localparam int SW_TRIP  = 1;
    localparam int SW_STBY  = 5;
    localparam int SW_READY = 6;
    // command source and terminal source codes
    localparam logic [3:0] SRC_SERIAL_A = 4'h3;
    localparam logic [3:0] SRC_SERIAL_B = 4'h4;
    localparam logic [3:0] SRC_CAN_A    = 4'h7;
    localparam logic [3:0] SRC_CAN_B    = 4'h8;
    localparam logic [3:0] TERM_MAX     = 4'h1;

    typedef enum logic [1:0] {
        MOTION_STOP  = 2'b00,
        MOTION_RUN   = 2'b01,
        MOTION_FAST  = 2'b11,
        MOTION_COAST = 2'b10
    } motion_e;

    typedef struct packed {
        logic [15:0]       cmd;
        logic [15:0]       speed;
        logic [15:0]       ramp;
        logic [31:0]       sync_id;
        logic [31:0]       emcy_id;
        logic              emcy_set;
        logic [15:0]       guard;
        logic [7:0]        life;
        logic [15:0]       emcy_gap;
        logic [15:0]       heartbeat;
        logic [3:0][31:0]  rx_map;
        logic [3:0][31:0]  tx_map;
        logic [2:0]        rx_cnt;
        logic [2:0]        tx_cnt;
        logic [31:0]       rdata;
        logic              ack;
        logic              err;
        motion_e           motion;
        logic              trip_rst;
        logic              term_ctl;
        logic [15:0]       speed_cmd;
        logic [15:0]       ramp_cmd;
        logic              ramp_valid;
        logic [15:0]       state_word;
    } state_s;
endpackage
